// File: rtl/iex_ext_chan.sv
// Purpose: one external interrupt channel with edge detect and stamp
// Assumes: the selected pin level is synchronous to i_clk
// Notes: the stamp counter runs regardless of the channel enable
`timescale 1ns/1ns
module iex_ext_chan
   import iex_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   iex_ext_if.chan ch
);
   logic prev_r, prev_nxt;
   logic [IEX_STAMP_W-1:0] cnt_r, cnt_nxt;
   logic fire_r, fire_nxt;
   logic arm_r, arm_nxt;
   logic edge_ok;
   // ---------------------------------------------------------------
   // edge qualification and counter
   // ---------------------------------------------------------------
   always_comb begin
      unique case (ch.edge_sel)
         IEX_EDGE_FALL: edge_ok = prev_r & ~ch.src_level;
         IEX_EDGE_RISE: edge_ok = ~prev_r & ch.src_level;
         IEX_EDGE_BOTH: edge_ok = prev_r ^ ch.src_level;
         default: edge_ok = 1'b0; // code 11 selects no trigger
      endcase
      // the held level is not real in the first cycle after reset, so a
      // pin idling high must not look like an edge then; a change of pin
      // selection can still look like one, software must allow for that
      edge_ok = edge_ok & arm_r;
      arm_nxt = 1'b1;
      prev_nxt = ch.src_level;
      // a valid edge restarts the stamp even when disabled
      cnt_nxt = edge_ok ? IEX_STAMP_RST : cnt_r + 16'h0001;
      fire_nxt = edge_ok & ch.enable;
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_r <= 1'b0;
         cnt_r <= IEX_STAMP_RST;
         fire_r <= 1'b0;
         arm_r <= 1'b0;
      end else begin
         arm_r <= arm_nxt;
         prev_r <= prev_nxt;
         cnt_r <= cnt_nxt;
         fire_r <= fire_nxt;
      end
   end
   assign ch.fire = fire_r;
   assign ch.stamp = cnt_r;
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   stamp_clear_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      edge_ok |=> cnt_r == IEX_STAMP_RST)
      else $error("stamp not cleared on edge");
   disabled_quiet_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      !ch.enable |=> !fire_r)
      else $error("disabled channel fired");
   stamp_run_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      !edge_ok |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("stamp counter not running");
endmodule // iex_ext_chan

// File: rtl/iex_ext_if.sv
// Purpose: bundle between the top and one external channel
// Assumes: one clock domain
// Notes: cfg from top, event and stamp back
`timescale 1ns/1ns
interface iex_ext_if;
   import iex_pkg::*;
   logic enable;
   logic [1:0] edge_sel;
   logic src_level;
   logic fire;
   logic [IEX_STAMP_W-1:0] stamp;
   modport top (output enable, output edge_sel, output src_level,
      input fire, input stamp);
   modport chan (input enable, input edge_sel, input src_level,
      output fire, output stamp);
endinterface

// File: rtl/iex_pkg.sv
// Purpose: shared constants for the interrupt expansion block
// Assumes: single 125 MHz clock domain
// Notes: widths and counts used by all three design files
package iex_pkg;
   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int unsigned IEX_NUM_REQ = 96;
   localparam int unsigned IEX_USED_REQ = 43;
   localparam int unsigned IEX_GRP_SIZE = 8;
   localparam int unsigned IEX_NUM_GRP = 12;
   localparam int unsigned IEX_VEC_W = 22;
   localparam int unsigned IEX_IDX_W = 7;
   localparam int unsigned IEX_NUM_EXT = 3;
   localparam int unsigned IEX_STAMP_W = 16;
   localparam int unsigned IEX_GPIO_W = 32;
   localparam int unsigned IEX_GPSEL_W = 5;
   // ---------------------------------------------------------------
   // timing: vector fetch plus context save, in processor cycles
   // ---------------------------------------------------------------
   localparam int unsigned IEX_FETCH_CYC = 8;
   localparam logic [3:0] IEX_FETCH_LAST = 4'(IEX_FETCH_CYC - 1);
   // reset values
   localparam logic [IEX_STAMP_W-1:0] IEX_STAMP_RST = 16'h0000;
   localparam logic [IEX_VEC_W-1:0] IEX_VEC_RST = 22'h00_0000;
   // edge selection codes
   typedef enum logic [1:0] {
      IEX_EDGE_FALL = 2'b00,
      IEX_EDGE_RISE = 2'b01,
      IEX_EDGE_BOTH = 2'b10
   } iex_edge_e;
   // fetch sequencer states
   typedef enum logic [1:0] {
      IEX_ST_IDLE = 2'b00,
      IEX_ST_FETCH = 2'b01,
      IEX_ST_SAVE = 2'b10
   } iex_state_e;
endpackage

// File: rtl/iex_top.sv
// Purpose: interrupt expansion block with external interrupt channels
// Assumes: one clock, processor acknowledges with a one-cycle pulse
// Notes: vector RAM written through a simple write port
//
// Overview of operation
// - accept up to 96 peripheral requests
// - 43 positions driven, rest unconnected
// - groups of 8 feed 12 lines
// - 96 vectors in writable RAM
// - present serviced request's vector on fetch
// - fetch and save take 8 cycles
// - per-request enable blocks group line
// - fixed order plus software enables
// - three maskable external channels
// - nmi-capable channel routes to line 13 or nmi
// - falling, rising or both edge trigger
// - each channel has its own enable
// - 16-bit stamp cleared on valid edge
// - any first-port pin selectable as source
`timescale 1ns/1ns
module iex_top
   import iex_pkg::*;
#(
   parameter int unsigned NUM_REQ = IEX_NUM_REQ,
   parameter int unsigned USED_REQ = IEX_USED_REQ
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [NUM_REQ-1:0] i_periph_req,
   input wire logic [NUM_REQ-1:0] i_req_enable,
   input wire logic i_vec_wr,
   input wire logic [IEX_IDX_W-1:0] i_vec_wr_idx,
   input wire logic [IEX_VEC_W-1:0] i_vec_wr_data,
   input wire logic [IEX_NUM_GRP-1:0] i_cpu_ack,
   input wire logic [IEX_GPIO_W-1:0] i_gpio_port_first,
   input wire logic [IEX_NUM_EXT-1:0] i_ext_enable,
   input wire logic [2*IEX_NUM_EXT-1:0] i_ext_edge_sel,
   input wire logic [IEX_NUM_EXT*IEX_GPSEL_W-1:0] i_ext_pin_sel,
   input wire logic i_nmi_route,
   output logic [IEX_NUM_GRP-1:0] o_cpu_irq_line,
   output logic o_cpu_irq_line_thirteen,
   output logic o_cpu_nmi,
   output logic o_ext_irq_one,
   output logic o_ext_irq_two,
   output logic [IEX_NUM_EXT*IEX_STAMP_W-1:0] o_ext_stamp,
   output logic o_vec_valid,
   output logic [IEX_VEC_W-1:0] o_vec,
   output logic [IEX_IDX_W-1:0] o_vec_idx,
   output logic o_busy
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [IEX_VEC_W-1:0] vec_ram [IEX_NUM_REQ];
   logic [IEX_NUM_REQ-1:0] pend_r, pend_nxt;
   logic [IEX_NUM_REQ-1:0] req_in;
   logic [IEX_NUM_GRP-1:0] line_r, line_nxt;
   iex_state_e st_r, st_nxt;
   logic [3:0] cyc_r, cyc_nxt;
   logic [IEX_IDX_W-1:0] idx_r, idx_nxt;
   logic [IEX_VEC_W-1:0] vec_r, vec_nxt;
   logic vval_r, vval_nxt;
   logic [IEX_IDX_W-1:0] pick_idx;
   logic pick_ok;
   logic [IEX_NUM_REQ-1:0] clr_mask;

   // lowest-numbered enabled pending request within a group
   function automatic logic [IEX_IDX_W-1:0] grp_pick(
      input logic [3:0] g,
      input logic [IEX_NUM_REQ-1:0] live);
      logic [IEX_IDX_W-1:0] r;
      // stay inside the group even if its enables dropped meanwhile
      r = IEX_IDX_W'(g * IEX_GRP_SIZE);
      for (int b = IEX_GRP_SIZE - 1; b >= 0; b--) begin
         if (live[g*IEX_GRP_SIZE+b]) r = IEX_IDX_W'(g*IEX_GRP_SIZE+b);
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // request inputs: only the used positions are wired
   // ---------------------------------------------------------------
   always_comb begin
      req_in = '0;
      for (int i = 0; i < IEX_NUM_REQ; i++) begin
         if (i < USED_REQ && i < NUM_REQ) begin
            req_in[i] = i_periph_req[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // vector RAM write port; no reset so it maps to real memory
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_vec_wr) vec_ram[i_vec_wr_idx] <= i_vec_wr_data;
   end

   // ---------------------------------------------------------------
   // pick the group being acknowledged; lowest group wins a tie
   // ---------------------------------------------------------------
   always_comb begin
      pick_idx = '0;
      pick_ok = 1'b0;
      for (int g = IEX_NUM_GRP - 1; g >= 0; g--) begin
         if (i_cpu_ack[g] && line_r[g]) begin
            pick_ok = 1'b1;
            pick_idx = grp_pick(4'(g), pend_r & i_req_enable);
         end
      end
   end

   // ---------------------------------------------------------------
   // fetch sequencer: 8 cycles of busy per serviced interrupt
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      cyc_nxt = cyc_r;
      idx_nxt = idx_r;
      vec_nxt = vec_r;
      vval_nxt = 1'b0;
      clr_mask = '0;
      unique case (st_r)
         IEX_ST_IDLE: begin
            if (pick_ok) begin
               st_nxt = IEX_ST_FETCH;
               idx_nxt = pick_idx;
               cyc_nxt = 4'h0;
            end
         end
         IEX_ST_FETCH: begin
            vec_nxt = vec_ram[idx_r];
            vval_nxt = 1'b1;
            clr_mask[idx_r] = 1'b1;
            st_nxt = IEX_ST_SAVE;
            cyc_nxt = 4'h1;
         end
         IEX_ST_SAVE: begin
            cyc_nxt = cyc_r + 4'h1;
            if (cyc_r == IEX_FETCH_LAST) st_nxt = IEX_ST_IDLE;
         end
         default: st_nxt = IEX_ST_IDLE; // code 11 is illegal
      endcase
      // new request wins over the clear in the same cycle
      pend_nxt = (pend_r & ~clr_mask) | req_in;
      for (int g = 0; g < IEX_NUM_GRP; g++) begin
         line_nxt[g] = |(pend_nxt[g*IEX_GRP_SIZE +: IEX_GRP_SIZE] &
            i_req_enable[g*IEX_GRP_SIZE +: IEX_GRP_SIZE]);
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= IEX_ST_IDLE;
         cyc_r <= 4'h0;
         idx_r <= '0;
         vec_r <= IEX_VEC_RST;
         vval_r <= 1'b0;
         pend_r <= '0;
         line_r <= '0;
      end else begin
         st_r <= st_nxt;
         cyc_r <= cyc_nxt;
         idx_r <= idx_nxt;
         vec_r <= vec_nxt;
         vval_r <= vval_nxt;
         pend_r <= pend_nxt;
         line_r <= line_nxt;
      end
   end
   assign o_cpu_irq_line = line_r;
   assign o_vec = vec_r;
   assign o_vec_valid = vval_r;
   assign o_vec_idx = idx_r;
   assign o_busy = (st_r != IEX_ST_IDLE);

   // ---------------------------------------------------------------
   // external channels: pin mux, edge logic in the leaf
   // ---------------------------------------------------------------
   iex_ext_if ext_if [IEX_NUM_EXT] ();
   logic [IEX_NUM_EXT-1:0] ext_fire;
   for (genvar c = 0; c < IEX_NUM_EXT; c++) begin : g_ext
      assign ext_if[c].enable = i_ext_enable[c];
      assign ext_if[c].edge_sel = i_ext_edge_sel[2*c +: 2];
      assign ext_if[c].src_level = i_gpio_port_first[
         i_ext_pin_sel[c*IEX_GPSEL_W +: IEX_GPSEL_W]];
      assign ext_fire[c] = ext_if[c].fire;
      assign o_ext_stamp[c*IEX_STAMP_W +: IEX_STAMP_W] = ext_if[c].stamp;
      iex_ext_chan u_chan (
         .i_clk(i_clk),
         .i_rst_b(i_rst_b),
         .ch(ext_if[c].chan)
      );
   end
   // pulses go straight to the core; channel 2 is the nmi-capable one
   assign o_ext_irq_one = ext_fire[0];
   assign o_ext_irq_two = ext_fire[1];
   assign o_cpu_irq_line_thirteen = ext_fire[2] & ~i_nmi_route;
   assign o_cpu_nmi = ext_fire[2] & i_nmi_route;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   busy_len_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      $rose(o_busy) |-> o_busy [*8] ##1 !o_busy)
      else $error("service sequence not 8 cycles");
   vec_after_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      $rose(o_busy) |=> o_vec_valid)
      else $error("vector not presented");
   pend_clear_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (st_r == IEX_ST_FETCH && !req_in[idx_r]) |=> !pend_r[$past(idx_r)])
      else $error("pending not cleared after fetch");
   line_pend_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_cpu_irq_line[0] |-> |pend_r[7:0])
      else $error("group line high with nothing pending");
   unused_req_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      pend_r[IEX_NUM_REQ-1:IEX_USED_REQ] == '0)
      else $error("unconnected position became pending");
   nmi_route_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      !(o_cpu_nmi && o_cpu_irq_line_thirteen))
      else $error("nmi channel routed twice");
   pick_low_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (st_r == IEX_ST_IDLE && i_cpu_ack[0] && line_r[0] && pend_r[0] &&
      i_req_enable[0]) |=> idx_r == 7'h00)
      else $error("lowest request not chosen");
   // a pending but disabled request must not light its group line
   en_gate_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_req_enable[7:0] & pend_nxt[7:0]) == 8'h00 |=> !o_cpu_irq_line[0])
      else $error("disabled group raised line");
   svc_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      $rose(o_vec_valid));
   nmi_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      o_cpu_nmi);
   xone_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      o_ext_irq_one);
endmodule // iex_top

// File: tb/iex_cpu_model.sv
// Purpose: processor core that acks group lines and takes vectors
// Assumes: ack is a one-cycle pulse given off the falling edge
// Notes: i_wait slows the answer so late acks are exercised too
`timescale 1ns/1ns
module iex_cpu_model
   import iex_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_go,
   input wire logic [3:0] i_wait,
   input wire logic [IEX_NUM_GRP-1:0] i_irq_line,
   input wire logic i_busy,
   input wire logic i_vec_valid,
   input wire logic [IEX_VEC_W-1:0] i_vec,
   input wire logic [IEX_IDX_W-1:0] i_vec_idx,
   output logic [IEX_NUM_GRP-1:0] o_ack,
   output logic [7:0] o_got_cnt,
   output logic [IEX_VEC_W-1:0] o_got_vec,
   output logic [IEX_IDX_W-1:0] o_got_idx,
   output logic [7:0] o_busy_len
);
   int grp;
   logic [7:0] run_r;
   // ---------------------------------------------------------------
   // service: lowest raised line first, never while a fetch runs
   // ---------------------------------------------------------------
   initial begin
      o_ack = '0;
      forever begin
         @(negedge i_clk);
         if (i_rst_b && i_go && i_busy === 1'b0 && (|i_irq_line)) begin
            repeat (i_wait) @(negedge i_clk);
            grp = 0;
            while (grp < 11 && i_irq_line[grp] !== 1'b1) grp++;
            o_ack[grp] = 1'b1;
            @(negedge i_clk);
            o_ack = '0;
         end
      end
   end
   // take the vector and time the fetch window
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_got_cnt <= '0;
         o_got_vec <= '0;
         o_got_idx <= '0;
         o_busy_len <= '0;
         run_r <= '0;
      end else begin
         if (i_vec_valid === 1'b1) begin
            o_got_cnt <= o_got_cnt + 8'h01;
            o_got_vec <= i_vec;
            o_got_idx <= i_vec_idx;
         end
         if (i_busy === 1'b1) begin
            run_r <= run_r + 8'h01;
         end else if (run_r != 8'h00) begin
            o_busy_len <= run_r;
            run_r <= '0;
         end
      end
   end
endmodule // iex_cpu_model

// File: tb/test_peripheral_and_external_irq_expander.sv
// Purpose: self-checking bench for the interrupt expansion block
// Assumes: inputs change on the falling edge only
// Notes: channel 2 is run twice, once per nmi route (c=3)
`timescale 1ns/1ns
module test_peripheral_and_external_irq_expander
   import iex_pkg::*;
;
   logic i_clk, i_rst_b, vec_wr, nmi_route, go, l13, nmi, x1, x2;
   logic vvalid, busy;
   logic [95:0] req, req_en;
   logic [6:0] wr_idx, vidx, got_idx;
   logic [21:0] wr_data, vec, got_vec;
   logic [11:0] ack, line;
   logic [31:0] gpio;
   logic [2:0] ext_en;
   logic [5:0] edge_sel;
   logic [14:0] pin_sel;
   logic [3:0] wait_cyc;
   logic [47:0] stamp;
   logic [7:0] got_cnt, busy_len;
   logic [21:0] vtab [96];
   int num_errors = 0, checks_done = 0, cycles = 0, served = 0;
   int pulses [4] = '{0, 0, 0, 0};

   iex_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_periph_req(req),
      .i_req_enable(req_en), .i_vec_wr(vec_wr), .i_vec_wr_idx(wr_idx),
      .i_vec_wr_data(wr_data), .i_cpu_ack(ack), .i_gpio_port_first(gpio),
      .i_ext_enable(ext_en), .i_ext_edge_sel(edge_sel),
      .i_ext_pin_sel(pin_sel), .i_nmi_route(nmi_route),
      .o_cpu_irq_line(line), .o_cpu_irq_line_thirteen(l13),
      .o_cpu_nmi(nmi), .o_ext_irq_one(x1), .o_ext_irq_two(x2),
      .o_ext_stamp(stamp), .o_vec_valid(vvalid), .o_vec(vec),
      .o_vec_idx(vidx), .o_busy(busy));
   iex_cpu_model cpu (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_go(go),
      .i_wait(wait_cyc), .i_irq_line(line), .i_busy(busy),
      .i_vec_valid(vvalid), .i_vec(vec), .i_vec_idx(vidx), .o_ack(ack),
      .o_got_cnt(got_cnt), .o_got_vec(got_vec), .o_got_idx(got_idx),
      .o_busy_len(busy_len));
   // ---------------------------------------------------------------
   // clock, pulse counters and hang guard
   // ---------------------------------------------------------------
   initial begin
      i_clk = 0;
      forever #4 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (x1 === 1'b1) pulses[0]++;
      if (x2 === 1'b1) pulses[1]++;
      if (l13 === 1'b1) pulses[2]++;
      if (nmi === 1'b1) pulses[3]++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (num_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // strobe held high: one write per cycle over the whole table
   task automatic load_vectors(input logic [21:0] salt);
      vec_wr = 1;
      for (int i = 0; i < 96; i++) begin
         wr_idx = 7'(i);
         wr_data = 22'(i * 22'h00_0d3b) ^ salt;
         vtab[i] = wr_data;
         @(negedge i_clk);
      end
      vec_wr = 0;
   endtask
   // one-cycle request pulse; pending must hold it until serviced
   task automatic raise(input logic [95:0] m);
      req = m;
      @(negedge i_clk);
      req = '0;
      repeat (3) @(negedge i_clk);
   endtask
   task automatic serve(input int i);
      int n;
      n = 0;
      while (got_cnt !== 8'(served + 1) && n < 200) begin
         @(negedge i_clk);
         n++;
      end
      n = 0;
      while (busy !== 1'b0 && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      @(negedge i_clk);
      served++;
      check(got_idx, i);
      check(got_vec, vtab[i]);
      check(busy_len, IEX_FETCH_CYC);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic scen_masked;
      req_en = ~(96'h1 << 5);
      raise((96'h1 << 5) | (96'h1 << 50) | (96'h1 << 95));
      check(line, 12'h000);
   endtask
   task automatic scen_service;
      raise(96'h181 | (96'h1 << 17) | (96'h1 << 19) | (96'h1 << 42));
      check(line, 12'h027);
      go = 1;
      serve(0);
      serve(7);
      serve(8);
      serve(17);
      serve(19);
      serve(42);
      check(line, 12'h000);
      wait_cyc = 3;
      load_vectors(22'h2a_5a5a);
      raise(96'h1 << 17);
      serve(17);
   endtask
   task automatic scen_ext;
      int ch, pin, e, x;
      int base [4];
      for (int c = 0; c < 4; c++) for (int m = 0; m < 5; m++) begin
         ch = (c > 2) ? 2 : c;
         pin = 7 * c + 3;
         nmi_route = (c == 3);
         pin_sel[ch*5 +: 5] = 5'(pin);
         edge_sel[ch*2 +: 2] = (m == 4) ? 2'b10 : 2'(m);
         ext_en[ch] = (m != 4);
         repeat (3) @(negedge i_clk);
         base = pulses;
         for (int k = 0; k < 2; k++) begin
            gpio[pin] = (k == 0);
            // the stamp reads zero in the cycle right after the edge
            repeat (1) @(negedge i_clk);
            if (m == 2 || m == 4 || m == 1 - k)
               check(stamp[ch*16 +: 16], 0);
            repeat (5) @(negedge i_clk);
            if (m == 2 || m == 4 || m == 1 - k)
               check(stamp[ch*16 +: 16], 5);
         end
         e = (m >= 3) ? 0 : (m == 2) ? 2 : 1;
         for (int j = 0; j < 4; j++) begin
            x = (j == c) ? e : 0;
            check(pulses[j] - base[j], x);
         end
         ext_en[ch] = 0;
         edge_sel[ch*2 +: 2] = 2'b11;
         @(negedge i_clk);
      end
   endtask
   // main sequence; flags, lines and stamps 1 and 2 are checked quiet once at the end of reset
   initial begin
      i_rst_b = 0;
      req = '0;
      req_en = '0;
      vec_wr = 0;
      wr_idx = '0;
      wr_data = '0;
      gpio = '0;
      ext_en = '0;
      edge_sel = '1;
      pin_sel = '1;
      nmi_route = 0;
      go = 0;
      wait_cyc = 0;
      repeat (6) @(negedge i_clk);
      check({busy, vvalid, line, l13, nmi, x1, x2}, 0);
      check(stamp[47:16], 0);
      i_rst_b = 1;
      @(negedge i_clk);
      load_vectors(22'h00_0000);
      scen_masked;
      scen_service;
      scen_ext;
      report_and_stop();
   end
endmodule // test_peripheral_and_external_irq_expander
